// file: dsic_pkg.sv
// Constants shared by the serial input control block of the converter.
package dsic_pkg;
  localparam int unsigned DATA_W      = 18;
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned CNT_W       = 5;
  localparam logic [17:0] RESET_MID   = 18'h20000;
  localparam logic [17:0] RESET_ZERO  = 18'h00000;
  localparam logic [17:0] MSB_FLIP    = 18'h20000;
  localparam logic [4:0]  CNT_ZERO    = 5'h00;
  localparam logic [4:0]  CNT_ONE     = 5'h01;
  localparam logic [4:0]  CNT_FULL    = 5'h18;
  typedef enum logic [1:0] {DSIC_IDLE, DSIC_SHIFT, DSIC_DONE} dsic_state_t;
endpackage

// file: dsic_sync.sv
// Two flip-flop synchroniser for a group of level signals.
`timescale 1ns/1ps
module dsic_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: dsic_top.sv
// Serial input shift register, input register and converter latch control.
`timescale 1ns/1ps

module dsic_top #(
  parameter int unsigned DATA_W = dsic_pkg::DATA_W,
  parameter int unsigned WORD_W = dsic_pkg::WORD_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              reset_n,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  output logic                   sdo,
  output logic                   sdo_oe_n,
  input  wire logic              latch_load_n,
  input  wire logic              reset_value_select,
  input  wire logic              input_format_select,
  input  wire logic              power_down_pin,
  input  wire logic              serial_out_select,
  output logic [DATA_W-1:0]      dac_code,
  output logic                   output_grounded,
  output logic                   word_done
);
  initial begin
    if (DATA_W != dsic_pkg::DATA_W || WORD_W != dsic_pkg::WORD_W) begin
      $error("dsic_top supports only an 18-bit field in a 24-bit word");
    end
  end

  // Link side: reset on the serial clock comes from either reset source.
  // The pin reset is asynchronous, so chip select and its value cannot glitch state.
  logic link_rst;
  assign link_rst = rst | ~reset_n;

  // Link domain, clocked by the serial clock inside frames and by chip select rising at each frame end.
  logic [WORD_W-1:0] shreg_q;
  logic [4:0]        bitcnt_q;
  logic              sdo_q;
  logic              sdo_oe_n_q;
  logic [DATA_W-1:0] sa_shift_q;
  logic              sa_load_q;
  logic              frame_tog_q;
  logic [DATA_W-1:0] frame_word_q;

  // Stand-alone output word, from the system domain, reloaded between frames and stable inside them.
  logic [DATA_W-1:0] input_reg_q;

  logic              cnt_full;
  assign cnt_full = (bitcnt_q >= dsic_pkg::CNT_FULL);

  // Deselection arms the first-edge flag, so every frame counts and reloads afresh.
  logic              frame_rst;
  assign frame_rst = link_rst | cs_n;

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      shreg_q  <= '0;
      bitcnt_q <= dsic_pkg::CNT_ZERO;
    end else if (!cs_n) begin
      shreg_q  <= {shreg_q[WORD_W-2:0], sdi};
      bitcnt_q <= sa_load_q ? dsic_pkg::CNT_ONE
                : (cnt_full ? bitcnt_q : bitcnt_q + dsic_pkg::CNT_ONE);
    end
  end

  // Stand-alone shifter reloads at the first edge of every frame.
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      sa_shift_q <= '0;
      sa_load_q  <= 1'b1;
    end else begin
      sa_load_q  <= 1'b0;
      sa_shift_q <= sa_load_q ? {input_reg_q[DATA_W-2:0], 1'b0}
                              : {sa_shift_q[DATA_W-2:0], 1'b0};
    end
  end

  logic sdo_next;
  assign sdo_next = serial_out_select
                  ? (sa_load_q ? input_reg_q[DATA_W-1] : sa_shift_q[DATA_W-1])
                  : shreg_q[WORD_W-1];

  // Output changes on the falling edge so the receiver samples on the next rise.
  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_next;
    end
  end

  // driven low, with sdo_oe_n high, when deselected
  // The first stand-alone bit must stand before any falling edge of the frame.
  assign sdo      = ~cs_n & ((serial_out_select & sa_load_q) ? input_reg_q[DATA_W-1] : sdo_q);
  assign sdo_oe_n = cs_n;

  // capture complete word
  // Chip select rising is the frame end; the serial clock is still, so cs_n clocks it.
  always_ff @(posedge cs_n or posedge link_rst) begin
    if (link_rst) begin
      frame_tog_q  <= 1'b0;
      frame_word_q <= '0;
    end else if (bitcnt_q == dsic_pkg::CNT_FULL) begin
      frame_tog_q  <= ~frame_tog_q;
      frame_word_q <= shreg_q[DATA_W-1:0];
    end
  end

  // System domain.
  logic       tog_s;
  logic       pd_s;
  logic       ld_n_s;
  logic       rsel_s;
  logic       fmt_s;
  logic       rstn_s;
  logic       tog_prev_q;
  logic       word_new;
  logic       hw_reset;
  logic       rst_done_q;
  logic [DATA_W-1:0] fmt_word;
  logic [DATA_W-1:0] reset_word;

  dsic_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({frame_tog_q, power_down_pin, latch_load_n, reset_value_select,
           input_format_select, reset_n}),
    .q   ({tog_s, pd_s, ld_n_s, rsel_s, fmt_s, rstn_s})
  );

  assign word_new = (tog_s != tog_prev_q);
  assign hw_reset = ~rstn_s | ~rst_done_q;
  assign reset_word = rsel_s ? dsic_pkg::RESET_MID : dsic_pkg::RESET_ZERO;
  assign fmt_word = fmt_s ? frame_word_q : (frame_word_q ^ dsic_pkg::MSB_FLIP);

  // Word value is stable well before the toggle passes the synchroniser.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_prev_q  <= 1'b0;
      rst_done_q  <= 1'b0;
      input_reg_q <= '0;
      word_done   <= 1'b0;
    end else begin
      tog_prev_q <= tog_s;
      rst_done_q <= rstn_s;
      word_done  <= word_new & ~hw_reset;
      if (hw_reset) begin
        input_reg_q <= reset_word;
      end else if (word_new) begin
        input_reg_q <= fmt_word;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_code        <= '0;
      output_grounded <= 1'b1;
    end else begin
      output_grounded <= pd_s;
      if (hw_reset) begin
        dac_code <= reset_word;
      end else if (!ld_n_s) begin
        dac_code <= input_reg_q;
      end
    end
  end
endmodule

// file: dsic_properties.sv
// Concurrent checks on the converter control ports.
`timescale 1ns/1ps
module dsic_properties #(
  parameter int unsigned DATA_W = dsic_pkg::DATA_W
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              reset_n,
  input wire logic              cs_n,
  input wire logic              sdo,
  input wire logic              sdo_oe_n,
  input wire logic              latch_load_n,
  input wire logic              reset_value_select,
  input wire logic              power_down_pin,
  input wire logic [DATA_W-1:0] dac_code,
  input wire logic              output_grounded,
  input wire logic              word_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence gnd_s; ##[1:4] output_grounded; endsequence
  oe_tracks_cs_a: assert property (sdo_oe_n == cs_n) else $error("oe wrong");
  sdo_idle_a: assert property (cs_n |-> !sdo) else $error("sdo active");
  ground_on_a: assert property ($rose(power_down_pin) |-> gnd_s) else $error("no gnd");
  ground_off_a: assert property ($fell(power_down_pin) |-> ##[1:4] !output_grounded)
    else $error("gnd stuck");
  done_pulse_a: assert property (word_done |=> !word_done) else $error("long done");
  done_after_cs_a: assert property (word_done |-> cs_n && $past(cs_n, 2))
    else $error("done in frame");
  reset_word_a: assert property ($fell(reset_n) && !latch_load_n |-> ##[2:6]
    dac_code == (reset_value_select ? dsic_pkg::RESET_MID : dsic_pkg::RESET_ZERO))
    else $error("bad reset word");
  // Resets reload the latch, so windows touching them are left out.
  latch_hold_a: assert property (latch_load_n && $past(latch_load_n, 3) && reset_n
    && $past(reset_n, 4) && !$past(rst, 5) |-> $stable(dac_code)) else $error("latch moved");
endmodule
bind dsic_top dsic_properties #(.DATA_W(DATA_W)) chk (.*);

// file: dsic_host.sv
// Serial host master model that frames words into the block.
`timescale 1ns/1ps
module dsic_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic send(input logic [23:0] w, input int n, output logic [23:0] got);
    got  = 24'h000000;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[23-i];
      #40 sclk = 1'b1;
      got = {got[22:0], sdo};
      #40 sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    // Inverted so a stale bit is never read as data.
    sdi = ~sdi;
  endtask
endmodule

// file: dsic_top_bench.sv
// Self-checking bench for the serial input control block.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t %h %h", $time, (a), (b)); end end
module dsic_top_bench;
  logic        clk = 1'b0, rst = 1'b1, reset_n = 1'b1, latch_load_n = 1'b0;
  logic        reset_value_select = 1'b1, input_format_select = 1'b1;
  logic        power_down_pin = 1'b0, serial_out_select = 1'b1;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, output_grounded, word_done;
  logic [17:0] dac_code;
  logic [23:0] got;
  int          miscompares = 0, checked = 0;
  dsic_top dut (.*);
  dsic_host host (.sclk, .cs_n, .sdi, .sdo);
  always #4 clk = ~clk;
  task automatic put(input logic [23:0] w, input int n);
    host.send(w, n, got);
    repeat (8) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(dac_code, 18'h20000)
    `CHK(sdo_oe_n, 1'b1)
    put(24'hA5AAA5, 24);
    `CHK(dac_code, 18'h1AAA5)
    @(posedge clk) input_format_select <= 1'b0;
    put(24'hA5AAA5, 24);
    `CHK(got[23:6], 18'h1AAA5)
    `CHK(dac_code, 18'h3AAA5)
    put(24'h000000, 20);
    `CHK(dac_code, 18'h3AAA5)
    $display("test frames done");
    @(posedge clk) latch_load_n <= 1'b1;
    put(24'h000123, 24);
    `CHK(dac_code, 18'h3AAA5)
    @(posedge clk) latch_load_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(dac_code, 18'h20123)
    $display("test latch done");
    @(posedge clk) serial_out_select <= 1'b0;
    put(24'h5A0F3C, 24);
    put(24'hC3A596, 24);
    `CHK(got, 24'h5A0F3C)
    $display("test daisy done");
    @(posedge clk) power_down_pin <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(output_grounded, 1'b1)
    power_down_pin <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(output_grounded, 1'b0)
    $display("test power done");
    reset_value_select <= 1'b0;
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(dac_code, 18'h00000)
    $display("test reset done");
    end_of_test;
  end
endmodule
